// ### core/servo_io_signal_mapper.sv
// Servo I/O signal mapper: input routing, feedback capture, status outputs, brake timing
`timescale 1ns/1ps
`default_nettype none

module servo_io_signal_mapper #(
  parameter int TICK_CYCLES = servo_io_pkg::TICK_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              ce,
  // Wishbone classic slave
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [servo_io_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [servo_io_pkg::DATA_W-1:0]   wb_dat_i,
  output logic      [servo_io_pkg::DATA_W-1:0]   wb_dat_o,
  output logic                                   wb_ack_o,
  // Sequence input terminals and drive core state
  input  wire logic [servo_io_pkg::IN_COUNT-1:0] seq_in,
  input  wire servo_io_pkg::drive_in_t           drive_in,
  // Function outputs
  output logic      [servo_io_pkg::IN_COUNT-1:0] seq_monitor,
  output logic                                   origin_slowdown_in,
  output logic                                   fwd_travel_inhibit,
  output logic                                   rev_travel_inhibit,
  output logic                                   slowdown_trigger,
  output logic                                   motor_power_en,
  output servo_io_pkg::status_fn_t               status_fn,
  output logic                                   out_pair_1,
  output logic                                   out_pair_2,
  output logic                                   out_pair_3
);

  typedef enum logic [1:0] {BRK_ENGAGED, BRK_RELEASED, BRK_STOP_DELAY, BRK_COAST} brk_state_t;

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  // Storage
  logic [31:0]                       rw_reg [servo_io_pkg::RW_COUNT];
  logic [31:0]                       cap_reg [3];
  logic [2:0]                        capf_reg;
  logic [servo_io_pkg::IN_COUNT-1:0] sync1_reg;
  logic [servo_io_pkg::IN_COUNT-1:0] sync2_reg;
  logic [servo_io_pkg::IN_COUNT-1:0] prev_reg;
  logic                              ack_reg;
  logic [31:0]                       rdata_reg;
  servo_io_pkg::status_fn_t          fn_reg;
  logic [2:0]                        pair_reg;
  logic                              slow_reg;
  logic                              fwd_reg;
  logic                              rev_reg;
  logic                              trig_reg;
  brk_state_t                        brk_state_reg;
  brk_state_t                        brk_state_next;
  logic [31:0]                       tick_cnt_reg;
  logic [31:0]                       brk_cnt_reg;

  // Magnitude of a signed word
  function automatic logic [31:0] mag(input logic signed [31:0] v);
    mag = v[31] ? 32'(-v) : 32'(v);
  endfunction

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    merge = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        merge[8*b +: 8] = new_v[8*b +: 8];
    end
  endfunction

  // Bus decode
  wire logic [3:0] bus_idx    = wb_adr_i[5:2];
  wire logic       bus_hi_ok  = (wb_adr_i[servo_io_pkg::ADR_W-1:6] == '0);
  wire logic       bus_req    = wb_cyc_i && wb_stb_i;
  wire logic       bus_rw_hit = bus_hi_ok && (bus_idx < 4'(servo_io_pkg::RW_COUNT));
  wire logic       bus_wr     = bus_req && wb_we_i && ack_reg;
  wire logic       st_w1c     = bus_wr && bus_hi_ok && (bus_idx == servo_io_pkg::IDX_STATUS)
                                && wb_sel_i[1];

  // Configuration fields
  wire logic [31:0] in_map  = rw_reg[servo_io_pkg::IDX_IN_MAP];
  wire logic [31:0] out_map = rw_reg[servo_io_pkg::IDX_OUT_MAP];
  wire servo_io_pkg::ctrl_mode_t mode =
    servo_io_pkg::ctrl_mode_t'(rw_reg[servo_io_pkg::IDX_CTRL][1:0]);
  wire logic [2:0] sel_slow = in_map[servo_io_pkg::POS_SLOWDOWN +: servo_io_pkg::IN_SEL_W];
  wire logic [2:0] sel_fwd  = in_map[servo_io_pkg::POS_FWD +: servo_io_pkg::IN_SEL_W];
  wire logic [2:0] sel_rev  = in_map[servo_io_pkg::POS_REV +: servo_io_pkg::IN_SEL_W];

  // input selection, code seven leaves a function unassigned
  wire logic [7:0] sync_ext  = {1'b0, sync2_reg};
  wire logic       slow_next = sync_ext[sel_slow];
  wire logic       fwd_next  = sync_ext[sel_fwd];
  wire logic       rev_next  = sync_ext[sel_rev];
  // slowdown triggers origin return deceleration regardless of mode
  wire logic       trig_next = slow_next && drive_in.homing_active;

  // capture functions reach only inputs four to six
  logic [2:0] ext_sel  [3];
  logic [2:0] ext_ok;
  logic [2:0] ext_rise;
  for (genvar e = 0; e < 3; e++)
  begin : g_ext
    assign ext_sel[e] = in_map[servo_io_pkg::POS_EXT_CAPTURE_1 + 4*e +: servo_io_pkg::IN_SEL_W];
    assign ext_ok[e]  = (ext_sel[e] >= servo_io_pkg::EXT_FIRST_IN)
                        && (ext_sel[e] <= servo_io_pkg::EXT_LAST_IN);
    assign ext_rise[e] = ext_ok[e] && sync2_reg[ext_sel[e]] && !prev_reg[ext_sel[e]];
  end

  // Status function levels from drive state
  wire logic [31:0] speed_mag = mag(drive_in.speed);
  wire logic        is_pos    = (mode == servo_io_pkg::MODE_POSITION);
  servo_io_pkg::status_fn_t fn_next;
  always_comb
  begin
    // alarm turns the fault output OFF
    fn_next.fault_out = !drive_in.alarm;
    fn_next.pos_done_a = is_pos
      && (mag(drive_in.pos_dev) <= rw_reg[servo_io_pkg::IDX_POS_A]);
    fn_next.pos_done_b = is_pos
      && (mag(drive_in.pos_dev) <= rw_reg[servo_io_pkg::IDX_POS_B]);
    // speed match only in speed mode
    fn_next.speed_match_out = (mode == servo_io_pkg::MODE_SPEED)
      && (mag(drive_in.speed_err) <= rw_reg[servo_io_pkg::IDX_SPD_MATCH]);
    // no encoder forces rotation detect on
    fn_next.rotating_out = !drive_in.encoder_present
      || (speed_mag > rw_reg[servo_io_pkg::IDX_ROT_LVL]);
    fn_next.ready_out = drive_in.main_ready && !drive_in.alarm;
    fn_next.current_clamped_out = drive_in.current_limited;
    // speed clamp reported only in torque mode
    fn_next.speed_clamped_out = (mode == servo_io_pkg::MODE_TORQUE) && drive_in.speed_limited;
    fn_next.brake_interlock_out = (brk_state_next == BRK_RELEASED)
      || (brk_state_next == BRK_COAST);
    fn_next.warn_out = drive_in.overload_warn || drive_in.regen_warn;
  end

  // any function except the fault output to any pair, indexed by function code
  // unassigned or unknown codes give OFF
  wire logic [servo_io_pkg::FN_COUNT-1:0] fn_vec = {
    fn_next.warn_out, fn_next.brake_interlock_out, fn_next.speed_clamped_out,
    fn_next.current_clamped_out, fn_next.ready_out, fn_next.rotating_out,
    fn_next.speed_match_out, fn_next.pos_done_b, fn_next.pos_done_a, 1'b0};
  logic [2:0] pair_next;
  for (genvar p = 0; p < servo_io_pkg::PAIR_COUNT; p++)
  begin : g_pair
    wire logic [3:0] code = out_map[servo_io_pkg::FN_W*p +: servo_io_pkg::FN_W];
    assign pair_next[p] = (code < 4'(servo_io_pkg::FN_COUNT)) ? fn_vec[code] : 1'b0;
  end

  // brake sequencing; an alarm counts as a servo off request
  wire logic servo_req = drive_in.servo_on_cmd && !drive_in.alarm;
  wire logic stopped   = speed_mag < rw_reg[servo_io_pkg::IDX_BRK_SPEED];
  wire logic tick      = (tick_cnt_reg == TICK_LAST);
  always_comb
  begin
    brk_state_next = brk_state_reg;
    case (brk_state_reg)
      BRK_ENGAGED:
        if (servo_req)
          brk_state_next = BRK_RELEASED;
      BRK_RELEASED:
        if (!servo_req)
          brk_state_next = stopped ? BRK_STOP_DELAY : BRK_COAST;
      BRK_STOP_DELAY:
        if (brk_cnt_reg >= rw_reg[servo_io_pkg::IDX_BRK_DELAY])
          brk_state_next = BRK_ENGAGED;
      BRK_COAST:
        if (stopped || (brk_cnt_reg >= rw_reg[servo_io_pkg::IDX_BRK_WAIT]))
          brk_state_next = BRK_ENGAGED;
      default:
        brk_state_next = BRK_ENGAGED;
    endcase
  end

  // Read mux; captures are read only, status takes only write-one clears of its capture flags
  wire logic [31:0] status_word =
    {16'h0000, fn_reg.fault_out, pair_reg, 1'b0, capf_reg, 1'b0, sync2_reg};
  logic [31:0] rdata_next;
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (bus_rw_hit)
      rdata_next = rw_reg[bus_idx];
    else if (bus_hi_ok && bus_idx == servo_io_pkg::IDX_STATUS)
      rdata_next = status_word;
    else if (bus_hi_ok && bus_idx >= servo_io_pkg::IDX_CAP1
             && bus_idx <= servo_io_pkg::IDX_CAP3)
      rdata_next = cap_reg[2'(bus_idx - servo_io_pkg::IDX_CAP1)];
  end

  // Bus handshake: one wait state, ack for one cycle, unmapped reads zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_reg   <= bus_req && !ack_reg;
      rdata_reg <= rdata_next;
    end
  end

  // defaults come from the reset values
  // pair one defaults to the brake interlock
  localparam logic [31:0] RST_VALS [servo_io_pkg::RW_COUNT] = '{
    servo_io_pkg::RST_IN_MAP, servo_io_pkg::RST_OUT_MAP, servo_io_pkg::RST_CTRL,
    servo_io_pkg::RST_POS_A, servo_io_pkg::RST_POS_B, servo_io_pkg::RST_SPD_MATCH,
    servo_io_pkg::RST_ROT_LVL, servo_io_pkg::RST_BRK_DELAY, servo_io_pkg::RST_BRK_SPEED,
    servo_io_pkg::RST_BRK_WAIT};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rw_reg <= RST_VALS;
    else if (ce && bus_wr && bus_rw_hit)
      rw_reg[bus_idx] <= merge(rw_reg[bus_idx], wb_dat_i, wb_sel_i);
  end

  // two-stage synchroniser, then an edge history stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end
    else if (ce)
    begin
      sync1_reg <= seq_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // capture the feedback counter on each active edge
  // Flag set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_reg  <= '{default: 32'h0000_0000};
      capf_reg <= 3'h0;
    end
    else if (ce)
    begin
      for (int e = 0; e < 3; e++)
      begin
        if (ext_rise[e])
          cap_reg[e] <= drive_in.feedback_count;
      end
      capf_reg <= (capf_reg & ~(st_w1c ? wb_dat_i[servo_io_pkg::POS_ST_CAPF +: 3] : 3'h0))
                  | ext_rise;
    end
  end

  // Registered function outputs and routed pairs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fn_reg   <= '0;
      pair_reg <= 3'h0;
      slow_reg <= 1'b0;
      fwd_reg  <= 1'b0;
      rev_reg  <= 1'b0;
      trig_reg <= 1'b0;
    end
    else if (ce)
    begin
      fn_reg   <= fn_next;
      pair_reg <= pair_next;
      slow_reg <= slow_next;
      fwd_reg  <= fwd_next;
      rev_reg  <= rev_next;
      trig_reg <= trig_next;
    end
  end

  // Millisecond tick and brake timer; the timer restarts on every state change
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_reg  <= 32'h0000_0000;
      brk_cnt_reg   <= 32'h0000_0000;
      brk_state_reg <= BRK_ENGAGED;
    end
    else if (ce)
    begin
      tick_cnt_reg  <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
      brk_state_reg <= brk_state_next;
      if (brk_state_next != brk_state_reg)
        brk_cnt_reg <= 32'h0000_0000;
      else if (tick && brk_cnt_reg != 32'hffff_ffff)
        brk_cnt_reg <= brk_cnt_reg + 32'h0000_0001;
    end
  end

  // Output drive
  assign wb_ack_o           = ack_reg;
  assign wb_dat_o           = rdata_reg;
  // monitor shows every synchronised input, input zero included
  assign seq_monitor        = sync2_reg;
  assign origin_slowdown_in = slow_reg;
  assign fwd_travel_inhibit = fwd_reg;
  assign rev_travel_inhibit = rev_reg;
  assign slowdown_trigger   = trig_reg;
  assign status_fn          = fn_reg;
  assign out_pair_1         = pair_reg[0];
  assign out_pair_2         = pair_reg[1];
  assign out_pair_3         = pair_reg[2];
  // Power stays on through the stop delay so the brake grips before torque drops
  assign motor_power_en     = (brk_state_reg == BRK_RELEASED)
                              || (brk_state_reg == BRK_STOP_DELAY);

  // Checks
  sequence s_servo_off_stopped;
    brk_state_reg == BRK_RELEASED && !servo_req && stopped && ce;
  endsequence
  sequence s_stop_hold;
    brk_state_reg == BRK_STOP_DELAY && !status_fn.brake_interlock_out && motor_power_en;
  endsequence

  a_brake_stop_seq: assert property (@(posedge clk) disable iff (!rst_n)
    s_servo_off_stopped |=> s_stop_hold)
    else $error("brake not engaged at stopped servo off");
  a_fault_polarity: assert property (@(posedge clk) disable iff (!rst_n)
    ce && drive_in.alarm |=> !status_fn.fault_out)
    else $error("fault output on during alarm");
  a_capture_value: assert property (@(posedge clk) disable iff (!rst_n)
    ce && ext_rise[0] |=> cap_reg[0] == $past(drive_in.feedback_count) && capf_reg[0])
    else $error("capture missed feedback count");
  a_sync_two_stage: assert property (@(posedge clk) disable iff (!rst_n)
    $past(ce) && $past(ce, 2) |-> seq_monitor == $past(seq_in, 2))
    else $error("input not two-stage synchronised");
  a_pos_done_window: assert property (@(posedge clk) disable iff (!rst_n)
    ce && is_pos && mag(drive_in.pos_dev) <= rw_reg[servo_io_pkg::IDX_POS_A]
    |=> status_fn.pos_done_a)
    else $error("positioning done missing");
  a_speed_match_mode: assert property (@(posedge clk) disable iff (!rst_n)
    ce && mode != servo_io_pkg::MODE_SPEED |=> !status_fn.speed_match_out)
    else $error("speed match outside speed mode");
  a_rotating_noenc: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !drive_in.encoder_present |=> status_fn.rotating_out)
    else $error("rotation detect off without encoder");
  a_pair_unassigned: assert property (@(posedge clk) disable iff (!rst_n)
    ce && out_map[7:4] == 4'h0 |=> !out_pair_2)
    else $error("unassigned pair driven on");
  a_slowdown_trig: assert property (@(posedge clk) disable iff (!rst_n)
    ce && drive_in.homing_active && slow_next |=> slowdown_trigger)
    else $error("slowdown trigger missing in origin return");
  a_pos_done_b: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !is_pos |=> !status_fn.pos_done_b)
    else $error("second positioning done outside position mode");
  a_rotating_level: assert property (@(posedge clk) disable iff (!rst_n)
    ce && drive_in.encoder_present && speed_mag > rw_reg[servo_io_pkg::IDX_ROT_LVL]
    |=> status_fn.rotating_out)
    else $error("rotation detect missing above threshold");
  a_warn_sources: assert property (@(posedge clk) disable iff (!rst_n)
    ce && (drive_in.overload_warn || drive_in.regen_warn) |=> status_fn.warn_out)
    else $error("warning output missing");
  a_speed_clamp_mode: assert property (@(posedge clk) disable iff (!rst_n)
    ce && mode != servo_io_pkg::MODE_TORQUE |=> !status_fn.speed_clamped_out)
    else $error("speed clamp outside torque mode");

endmodule

`default_nettype wire

// ### core/servo_io_pkg.sv
// Shared constants, types and register map of the servo I/O signal mapper
package servo_io_pkg;

  localparam int DATA_W    = 32;
  localparam int ADR_W     = 8;
  localparam int IN_COUNT  = 7;
  localparam int PAIR_COUNT = 3;

  // Register indices; byte address is index times four
  localparam logic [3:0] IDX_IN_MAP    = 4'h0;
  localparam logic [3:0] IDX_OUT_MAP   = 4'h1;
  localparam logic [3:0] IDX_CTRL      = 4'h2;
  localparam logic [3:0] IDX_POS_A     = 4'h3;
  localparam logic [3:0] IDX_POS_B     = 4'h4;
  localparam logic [3:0] IDX_SPD_MATCH = 4'h5;
  localparam logic [3:0] IDX_ROT_LVL   = 4'h6;
  localparam logic [3:0] IDX_BRK_DELAY = 4'h7;
  localparam logic [3:0] IDX_BRK_SPEED = 4'h8;
  localparam logic [3:0] IDX_BRK_WAIT  = 4'h9;
  localparam logic [3:0] IDX_STATUS    = 4'ha;
  localparam logic [3:0] IDX_CAP1      = 4'hb;
  localparam logic [3:0] IDX_CAP3      = 4'hd;
  localparam int         RW_COUNT      = 10;

  // Field positions
  localparam int IN_SEL_W     = 3;
  localparam int POS_SLOWDOWN = 0;
  localparam int POS_FWD      = 4;
  localparam int POS_REV      = 8;
  localparam int POS_EXT_CAPTURE_1     = 12;
  localparam int FN_W         = 4;
  localparam int POS_ST_CAPF  = 8;
  localparam int POS_ST_PAIRS = 12;
  localparam int POS_ST_FAULT = 15;
  localparam logic [2:0] EXT_FIRST_IN = 3'h4;
  localparam logic [2:0] EXT_LAST_IN  = 3'h6;

  // Reset values
  localparam logic [31:0] RST_IN_MAP    = 32'h0065_4213;
  localparam logic [31:0] RST_OUT_MAP   = 32'h0000_0008;
  localparam logic [31:0] RST_CTRL      = 32'h0000_0000;
  localparam logic [31:0] RST_POS_A     = 32'h0000_0007;
  localparam logic [31:0] RST_POS_B     = 32'h0000_0007;
  localparam logic [31:0] RST_SPD_MATCH = 32'h0000_000a;
  localparam logic [31:0] RST_ROT_LVL   = 32'h0000_0014;
  localparam logic [31:0] RST_BRK_DELAY = 32'h0000_0000;
  localparam logic [31:0] RST_BRK_SPEED = 32'h0000_0064;
  localparam logic [31:0] RST_BRK_WAIT  = 32'h0000_0032;

  // Brake timing tick: one millisecond at the 40 MHz system clock
  localparam int CLK_KHZ     = 40000;
  localparam int TICK_MS     = 1;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;

  typedef enum logic [1:0] {MODE_POSITION, MODE_SPEED, MODE_TORQUE} ctrl_mode_t;

  typedef enum logic [3:0] {
    FN_NONE, FN_POS_A, FN_POS_B, FN_SPEED_MATCH, FN_ROTATING, FN_READY,
    FN_CUR_CLAMP, FN_SPD_CLAMP, FN_BRAKE, FN_WARN, FN_COUNT
  } out_fn_t;

  // Live state reported by the drive core
  typedef struct packed {
    logic               alarm;
    logic               encoder_present;
    logic               main_ready;
    logic               servo_on_cmd;
    logic               homing_active;
    logic               current_limited;
    logic               speed_limited;
    logic               overload_warn;
    logic               regen_warn;
    logic signed [31:0] pos_dev;
    logic signed [31:0] speed_err;
    logic signed [31:0] speed;
    logic        [31:0] feedback_count;
  } drive_in_t;

  // Status functions, all active high (ON)
  typedef struct packed {
    logic fault_out;
    logic pos_done_a;
    logic pos_done_b;
    logic speed_match_out;
    logic rotating_out;
    logic ready_out;
    logic current_clamped_out;
    logic speed_clamped_out;
    logic brake_interlock_out;
    logic warn_out;
  } status_fn_t;

endpackage

// ### dv/sensor_field.sv
// Far-side model: limit switches and latch sensors as terminal levels
`timescale 1ns/1ps
`default_nettype none

module sensor_field (
  input  wire logic       clk,
  input  wire logic [6:0] want,
  output var  logic [6:0] level
);
  // Sensors switch just after an edge, so the mapper never samples a moving level
  initial level = 7'h00;
  always @(posedge clk)
  begin
    level <= want;
  end
endmodule

`default_nettype wire

// ### dv/servo_io_signal_mapper_test.sv
// Self-checking bench for the servo I/O signal mapper
`timescale 1ns/1ps
`default_nettype none

module servo_io_signal_mapper_test;
  logic                    clk;
  logic                    rst_n;
  logic                    cyc;
  logic                    stb;
  logic                    we;
  logic [7:0]              adr;
  logic [31:0]             dwr;
  logic [31:0]             drd;
  logic                    ack;
  logic [6:0]              want;
  logic [6:0]              seq;
  logic [6:0]              mon;
  logic                    slow;
  logic                    fwd;
  logic                    rev;
  logic                    trig;
  logic                    pwr;
  logic                    p1;
  logic                    p2;
  logic                    p3;
  servo_io_pkg::drive_in_t  din;
  servo_io_pkg::status_fn_t st;
  int                      fail_count;
  int                      n_checks;

  // Small tick keeps brake timing short in simulation
  servo_io_signal_mapper #(.TICK_CYCLES(4)) servo_io_signal_mapper_i (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dwr), .wb_dat_o(drd),
    .wb_ack_o(ack), .seq_in(seq), .drive_in(din), .seq_monitor(mon),
    .origin_slowdown_in(slow), .fwd_travel_inhibit(fwd), .rev_travel_inhibit(rev),
    .slowdown_trigger(trig), .motor_power_en(pwr), .status_fn(st),
    .out_pair_1(p1), .out_pair_2(p2), .out_pair_3(p3)
  );

  sensor_field sensor_field_i (.clk(clk), .want(want), .level(seq));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; values seen here are those sampled at the edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dwr <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    q = drd;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40)
    begin
      fail_count++;
      summarize();
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  initial
  begin
    fail_count = 0;
    n_checks = 0;
    {cyc, stb, we, adr, dwr, want} = '0;
    din = '0;
    din.encoder_present = 1'b1;
    din.speed = 32'sd50;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Register defaults and an unmapped word
    rd(8'h00, 32'h0065_4213);
    rd(8'h04, 32'h0000_0008);
    rd(8'h38, 32'h0000_0000);
    // Default input mapping with origin return active
    want <= 7'h0b;
    din.homing_active <= 1'b1;
    repeat (6) @(posedge clk);
    chk({fwd, rev, slow}, 3'b101);
    chk(trig, 1'b1);
    chk(mon, 7'h0b);
    // Move forward inhibit to input 0 and reverse to input 1
    wr(8'h00, 32'h0065_4103);
    repeat (4) @(posedge clk);
    chk({fwd, rev}, 2'b11);
    // Capture on input 4, then the counter moves on
    din.feedback_count <= 32'h1234_5678;
    want[4] <= 1'b1;
    repeat (6) @(posedge clk);
    din.feedback_count <= 32'h0000_0abc;
    rd(8'h2c, 32'h1234_5678);
    // Capture 1 moved to input 0 is refused, so edges there leave it alone
    wr(8'h00, 32'h0065_0103);
    want[0] <= 1'b0;
    repeat (4) @(posedge clk);
    want[0] <= 1'b1;
    repeat (6) @(posedge clk);
    rd(8'h2c, 32'h1234_5678);
    // Completion range is inclusive on magnitude
    din.pos_dev <= -32'sd7;
    repeat (3) @(posedge clk);
    chk(st.pos_done_a, 1'b1);
    din.pos_dev <= 32'sd8;
    repeat (3) @(posedge clk);
    chk({st.pos_done_a, st.pos_done_b}, 2'b00);
    // Second range widened on its own
    wr(8'h10, 32'h0000_0008);
    repeat (2) @(posedge clk);
    chk({st.pos_done_a, st.pos_done_b}, 2'b01);
    // Speed mode conformity window
    wr(8'h08, 32'h0000_0001);
    din.speed_err <= 32'sd10;
    repeat (3) @(posedge clk);
    chk(st.speed_match_out, 1'b1);
    // Rotation threshold is strict, encoder loss forces it on
    chk(st.rotating_out, 1'b1);
    din.speed <= 32'sd20;
    repeat (3) @(posedge clk);
    chk(st.rotating_out, 1'b0);
    din.encoder_present <= 1'b0;
    repeat (3) @(posedge clk);
    chk(st.rotating_out, 1'b1);
    din.current_limited <= 1'b1;
    repeat (3) @(posedge clk);
    chk(st.current_clamped_out, 1'b1);
    // Torque mode speed clamp
    wr(8'h08, 32'h0000_0002);
    din.speed_limited <= 1'b1;
    repeat (3) @(posedge clk);
    chk(st.speed_clamped_out, 1'b1);
    // Warning routed to pair 2, pair 3 left empty
    wr(8'h04, 32'h0000_0098);
    din.regen_warn <= 1'b1;
    repeat (3) @(posedge clk);
    chk({st.warn_out, p2, p3}, 3'b110);
    chk(p2, 1'b1);
    chk(p3, 1'b0);
    // Servo on releases the brake and powers the stage
    din.servo_on_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    chk(pwr, 1'b1);
    chk(p1, 1'b1);
    chk(st.fault_out, 1'b1);
    din.alarm <= 1'b1;
    repeat (3) @(posedge clk);
    chk(st.fault_out, 1'b0);
    // Stopped release: brake grips at once, power drops after zero delay
    chk({pwr, p1}, 2'b00);
    // Release while turning: power cut, brake held off until the wait runs out
    wr(8'h24, 32'h0000_0003);
    din.alarm <= 1'b0;
    din.speed <= 32'sd200;
    repeat (3) @(posedge clk);
    din.servo_on_cmd <= 1'b0;
    repeat (3) @(posedge clk);
    chk({pwr, p1}, 2'b01);
    repeat (17) @(posedge clk);
    chk({pwr, p1}, 2'b00);
    summarize();
  end
endmodule

`default_nettype wire
